// ---- rtl/slfw_pkg.sv ----
// Purpose: constants and types for the segment lcd frame waveform core
// Assumes: one clock, synchronous active-low reset
// Notes: register indices are word indices on the plain register port
//
// Overview of operation
// - one pixel bit per common/segment pair, set=dark
// - unused pixel bits stay plain storage
// - segments 0-23 from registers 0-11 by common
// - segments 24-45 from registers 12-23 by common
// - static frame: clock/(4*prescale*32)
// - two commons: clock/(2*prescale*32*2)
// - three/four commons: clock/(prescale*32*commons)
// - timing clock from three selectable sources
// - waveforms give zero net dc
// - commons mark slices, segments carry active data
// - pixel sees only dark or clear level
// - per-frame type inverts within each slice
// - two-frame type inverts at frame boundary
// - main-oscillator source stops at sleep always
// - flag set when running flag falls
// - two-frame type flags frame boundaries
// - common count select chooses active commons
// - frame begins at first common leading edge
// - no frame flag for per-frame or static
// - late pixel write dropped, error flag set
package slfw_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int NUM_PIX_REGS = 24;
  localparam int NUM_COMS = 4;
  localparam int NUM_SEGS = 46;
  localparam int SEG_SPLIT = 24;
  localparam int REGS_PER_COM = 3;
  localparam int HI_BANK_BASE = 12;
  localparam int SUBSTEPS = 32;
  localparam int MAIN_DIV = 256;

  localparam logic [4:0] REG_PANEL_CTRL = 5'h18;
  localparam logic [4:0] REG_PRESCALE = 5'h19;
  localparam logic [4:0] REG_STATUS = 5'h1A;

  // panel control field positions
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_SLEEP_SEL_BIT = 6;
  localparam int CTL_LATE_WRITE_ERROR_FLAG_BIT = 5;
  localparam int CTL_WTYPE_BIT = 4;
  localparam int CTL_SRC_LSB = 2;
  localparam int CTL_MUX_LSB = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [3:0] PRESCALE_RESET = 4'h0;
  localparam int STAT_IRQ_BIT = 0;

  localparam logic [1:0] SRC_MAIN_DIV = 2'h0;
  localparam logic [1:0] SRC_CRYSTAL = 2'h1;
  localparam logic [1:0] SRC_LFINT = 2'h2;

  localparam logic [1:0] MUX_STATIC = 2'h0;
  localparam logic [1:0] MUX_TWO = 2'h1;
  localparam logic [1:0] MUX_THREE = 2'h2;
  localparam logic [1:0] MUX_FOUR = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_STOPPING = 3'b100
  } slfw_state_type;

  // frame configuration, latched only at frame start
  typedef struct packed {
    logic [1:0] mux;
    logic wtype;
    logic [3:0] prescale;
  } slfw_cfg_type;

endpackage

// ---- rtl/slfw_core.sv ----
// Purpose: segment lcd frame timing, waveform phase and pixel registers
// Assumes: source ticks are single-cycle enables synchronous to CLOCK
// Notes: drive outputs are logic codes for an external bias ladder
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module slfw_core
  import slfw_pkg::*;
#(
  parameter int MAIN_DIVIDE = MAIN_DIV
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // register port
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [DATA_W-1:0] REG_RDATA,
  // timing sources and sleep
  input wire logic MAIN_OSC_TICK,
  input wire logic CRYSTAL_TICK,
  input wire logic LFINT_TICK,
  input wire logic SLEEP_REQ,
  // status
  output logic MODULE_RUNNING,
  output logic LCD_IRQ_FLAG,
  // glass drive: common active, common phase, segment dark-data xor phase
  output logic [NUM_COMS-1:0] COM_ACTIVE,
  output logic [NUM_COMS-1:0] COM_SELECT,
  output logic COM_PHASE,
  output logic [NUM_SEGS-1:0] SEG_LEVEL
);

  // ************************************************************
  // registers
  // ************************************************************
  logic [DATA_W-1:0] pix_r [NUM_PIX_REGS];
  logic [DATA_W-1:0] ctl_r;
  logic [3:0] prescale_r;
  logic irq_r;
  slfw_state_type state_r;
  slfw_cfg_type cfg_r;
  logic [7:0] main_div_r;
  logic [4:0] sub_r;
  logic [3:0] pre_cnt_r;
  logic [1:0] mul_r;
  logic [1:0] com_r;
  logic phase;
  logic frame_odd_r;
  logic write_open_r;
  logic running_q_r;

  logic enable;
  logic sleep_sel;
  logic [1:0] src_sel;
  logic tick;
  logic stopped;
  logic step;
  logic slice_end;
  logic frame_end;
  logic pix_wr;
  logic frame_irq;

  assign enable = ctl_r[CTL_ENABLE_BIT];
  assign sleep_sel = ctl_r[CTL_SLEEP_SEL_BIT];
  assign src_sel = ctl_r[CTL_SRC_LSB +: 2];

  // multiplier ahead of the prescaler: 4 static, 2 two-common, else 1
  function automatic logic [1:0] mul_last(input logic [1:0] mux);
    unique case (mux)
      MUX_STATIC: mul_last = 2'h3;
      MUX_TWO: mul_last = 2'h1;
      default: mul_last = 2'h0;
    endcase
  endfunction

  // ************************************************************
  // timing source select and sleep stop
  // ************************************************************
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      main_div_r <= 8'h00;
    end else if (MAIN_OSC_TICK) begin
      main_div_r <= (main_div_r == 8'(MAIN_DIVIDE - 1)) ? 8'h00 : main_div_r + 8'h01;
    end
  end

  // main oscillator path halts in sleep whatever the sleep select
  assign stopped = SLEEP_REQ && (sleep_sel || src_sel == SRC_MAIN_DIV);

  always_comb begin
    unique case (src_sel)
      SRC_MAIN_DIV: tick = MAIN_OSC_TICK && main_div_r == 8'(MAIN_DIVIDE - 1);
      SRC_CRYSTAL: tick = CRYSTAL_TICK;
      default: tick = LFINT_TICK;
    endcase
  end

  // ************************************************************
  // frame divider: mul x (prescale+1) x 32 x commons
  // ************************************************************
  assign step = tick && !stopped && state_r != ST_IDLE;
  assign slice_end = step && sub_r == 5'(SUBSTEPS - 1) && pre_cnt_r == cfg_r.prescale &&
                     mul_r == mul_last(cfg_r.mux);
  assign frame_end = slice_end && com_r == cfg_r.mux;

  always_ff @(posedge CLOCK) begin
    if (!RESETN || state_r == ST_IDLE) begin
      mul_r <= 2'h0;
      pre_cnt_r <= 4'h0;
      sub_r <= 5'h00;
    end else if (step) begin
      if (mul_r != mul_last(cfg_r.mux)) begin
        mul_r <= mul_r + 2'h1;
      end else begin
        mul_r <= 2'h0;
        if (pre_cnt_r != cfg_r.prescale) begin
          pre_cnt_r <= pre_cnt_r + 4'h1;
        end else begin
          pre_cnt_r <= 4'h0;
          sub_r <= sub_r + 5'h01;
        end
      end
    end
  end

  // slice counter and phase; per-frame type flips mid-slice
  always_ff @(posedge CLOCK) begin
    if (!RESETN || state_r == ST_IDLE) begin
      com_r <= 2'h0;
      frame_odd_r <= 1'b0;
    end else if (slice_end) begin
      com_r <= frame_end ? 2'h0 : com_r + 2'h1;
      if (frame_end) begin
        frame_odd_r <= !frame_odd_r;
      end
    end
  end

  always_comb begin
    if (cfg_r.wtype) begin
      phase = frame_odd_r;
    end else begin
      phase = sub_r[$bits(sub_r)-1];
    end
  end

  // configuration sampled only at frame start
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      cfg_r <= '0;
    end else if (state_r == ST_IDLE || frame_end) begin
      cfg_r.mux <= ctl_r[CTL_MUX_LSB +: 2];
      cfg_r.wtype <= ctl_r[CTL_WTYPE_BIT];
      cfg_r.prescale <= prescale_r;
    end
  end

  // ************************************************************
  // enable / shutdown state machine
  // ************************************************************
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: if (enable) state_r <= ST_RUN;
        ST_RUN: if (!enable) state_r <= ST_STOPPING;
        ST_STOPPING: if (frame_end) state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // write window and interrupt flag
  // ************************************************************
  // frame flag only for two-frame type with multiplex
  assign frame_irq = frame_end && cfg_r.wtype && cfg_r.mux != MUX_STATIC;
  assign pix_wr = REG_WR && REG_ADDR < ADDR_W'(NUM_PIX_REGS);

  // writes legal for one slice after the frame flag in two-frame mode
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      write_open_r <= 1'b0;
    end else if (frame_irq) begin
      write_open_r <= 1'b1;
    end else if (slice_end) begin
      write_open_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      running_q_r <= 1'b0;
    end else begin
      running_q_r <= state_r != ST_IDLE;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      irq_r <= 1'b0;
    end else if ((running_q_r && state_r == ST_IDLE) || frame_irq) begin
      // set beats a same-cycle clear
      irq_r <= 1'b1;
    end else if (REG_WR && REG_ADDR == REG_STATUS && REG_WDATA[STAT_IRQ_BIT]) begin
      irq_r <= 1'b0;
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  logic late_wr;
  assign late_wr = pix_wr && state_r != ST_IDLE && cfg_r.wtype &&
                   cfg_r.mux != MUX_STATIC && !write_open_r;

  generate
    for (genvar i = 0; i < NUM_PIX_REGS; i++) begin : g_pix
      // plain storage, any bit usable as memory
      always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
          pix_r[i] <= 8'h00;
        end else if (pix_wr && !late_wr && REG_ADDR == ADDR_W'(i)) begin
          pix_r[i] <= REG_WDATA;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      ctl_r <= CTL_RESET;
      prescale_r <= PRESCALE_RESET;
    end else begin
      if (REG_WR && REG_ADDR == REG_PANEL_CTRL) begin
        // error bit only clears by software; set wins below
        ctl_r <= {REG_WDATA[CTL_ENABLE_BIT:CTL_SLEEP_SEL_BIT], ctl_r[CTL_LATE_WRITE_ERROR_FLAG_BIT] & REG_WDATA[CTL_LATE_WRITE_ERROR_FLAG_BIT],
                  REG_WDATA[CTL_WTYPE_BIT:CTL_MUX_LSB]};
      end
      if (late_wr) begin
        // dropped write is reported
        ctl_r[CTL_LATE_WRITE_ERROR_FLAG_BIT] <= 1'b1;
      end
      if (REG_WR && REG_ADDR == REG_PRESCALE) begin
        prescale_r <= REG_WDATA[3:0];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      if (REG_ADDR < ADDR_W'(NUM_PIX_REGS)) begin
        REG_RDATA <= pix_r[REG_ADDR];
      end else if (REG_ADDR == REG_PANEL_CTRL) begin
        REG_RDATA <= ctl_r;
      end else if (REG_ADDR == REG_PRESCALE) begin
        REG_RDATA <= {4'h0, prescale_r};
      end else if (REG_ADDR == REG_STATUS) begin
        REG_RDATA <= {6'h00, running_q_r, irq_r};
      end else begin
        REG_RDATA <= 8'h00;
      end
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // ************************************************************
  // glass drive
  // ************************************************************
  // data bit for segment s under common c
  function automatic logic pix_bit(input int c, input int s);
    int idx;
    idx = (s < SEG_SPLIT) ? c * REGS_PER_COM + s / DATA_W :
          HI_BANK_BASE + c * REGS_PER_COM + (s - SEG_SPLIT) / DATA_W;
    pix_bit = pix_r[idx][(s < SEG_SPLIT ? s : s - SEG_SPLIT) % DATA_W];
  endfunction

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      MODULE_RUNNING <= 1'b0;
      LCD_IRQ_FLAG <= 1'b0;
      COM_PHASE <= 1'b0;
      COM_ACTIVE <= '0;
      COM_SELECT <= '0;
    end else begin
      MODULE_RUNNING <= state_r != ST_IDLE;
      LCD_IRQ_FLAG <= irq_r;
      COM_PHASE <= phase;
      for (int c = 0; c < NUM_COMS; c++) begin
        // unused commons left to the pins
        COM_ACTIVE[c] <= state_r != ST_IDLE && c <= int'(cfg_r.mux);
        // selected slice marks its own common
        COM_SELECT[c] <= state_r != ST_IDLE && com_r == 2'(c);
      end
    end
  end

  // segment is opposite to the selected common for dark, equal for clear;
  // phase flips keep the average at zero
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      SEG_LEVEL <= '0;
    end else begin
      for (int s = 0; s < NUM_SEGS; s++) begin
        SEG_LEVEL[s] <= (state_r != ST_IDLE) && (pix_bit(int'(com_r), s) ^ phase);
      end
    end
  end

endmodule

// ---- testbench/slfw_checker.sv ----
// Purpose: port assertions for the lcd frame waveform core
// Assumes: one clock, synchronous active-low reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
module slfw_checker
  import slfw_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // register port
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  // status and drive
  input wire logic MODULE_RUNNING,
  input wire logic LCD_IRQ_FLAG,
  input wire logic [NUM_COMS-1:0] COM_ACTIVE,
  input wire logic [NUM_COMS-1:0] COM_SELECT
);
  // ****
  // assertions
  // ****
  // flag lags a clear write by two edges
  logic clr_d1_r;
  logic clr_d2_r;
  always_ff @(posedge CLOCK) begin
    clr_d1_r <= REG_WR && REG_ADDR == REG_STATUS && REG_WDATA[0];
    clr_d2_r <= clr_d1_r;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  AST_RDATA_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == '0)
    else $error("read data not idle");
  AST_SEL_ONEHOT: assert property (MODULE_RUNNING && $past(MODULE_RUNNING) |-> $onehot(COM_SELECT))
    else $error("slice select not one-hot");
  AST_SEL_ACTIVE: assert property ((COM_SELECT & ~COM_ACTIVE) == '0)
    else $error("slice on unused common");
  AST_ACTIVE_MASK: assert property (COM_ACTIVE inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
    else $error("common mask not contiguous");
  AST_SEL_ORDER: assert property (MODULE_RUNNING && $past(MODULE_RUNNING) && $changed(COM_SELECT) |->
    (COM_SELECT == ($past(COM_SELECT) << 1) || COM_SELECT == 4'h1)) else $error("slice order broken");
  AST_SLICE_HOLD: assert property (MODULE_RUNNING && $changed(COM_SELECT) |=>
    ($stable(COM_SELECT) || !MODULE_RUNNING) [*8]) else $error("slice too short");
  AST_IRQ_ON_STOP: assert property ($past(RESETN) && $fell(MODULE_RUNNING) |-> ##[0:2] LCD_IRQ_FLAG)
    else $error("no flag on shutdown");
  AST_IRQ_STICKY: assert property ($past(RESETN) && $past(LCD_IRQ_FLAG) && !clr_d1_r && !clr_d2_r |-> LCD_IRQ_FLAG)
    else $error("flag dropped without clear");
  cover property ($fell(MODULE_RUNNING));
  cover property (MODULE_RUNNING && $rose(LCD_IRQ_FLAG));
  cover property (COM_SELECT == 4'h8);
endmodule

// ---- testbench/slfw_glass.sv ----
// Purpose: passive glass model latching each slice's pixel states
// Assumes: dark pixel shows segment level unlike common phase
// Notes: flips counted away from slice edges only
`timescale 1ns/1ps
module slfw_glass
  import slfw_pkg::*;
(
  // drive lines
  input wire logic CLOCK,
  input wire logic MODULE_RUNNING,
  input wire logic [NUM_COMS-1:0] COM_SELECT,
  input wire logic COM_PHASE,
  input wire logic [NUM_SEGS-1:0] SEG_LEVEL,
  // observed state
  output logic [NUM_SEGS-1:0] dark [NUM_COMS],
  output int last_flips
);
  // ****
  // slice observation
  // ****
  logic [NUM_COMS-1:0] sel_d1 = '0;
  logic [NUM_COMS-1:0] sel_d2 = '0;
  logic ph_d1 = 1'b0;
  int flips = 0;
  always @(posedge CLOCK) begin
    sel_d1 <= COM_SELECT;
    sel_d2 <= sel_d1;
    ph_d1 <= COM_PHASE;
    for (int c = 0; c < NUM_COMS; c++) begin
      if (MODULE_RUNNING && COM_SELECT[c]) dark[c] <= SEG_LEVEL ^ {NUM_SEGS{COM_PHASE}};
    end
    if (COM_SELECT != sel_d1) begin
      last_flips <= flips;
      flips <= 0;
    end else if (COM_SELECT == sel_d2 && COM_PHASE != ph_d1) begin
      flips <= flips + 1;
    end
  end
endmodule

// ---- testbench/segment_lcd_frame_waveform_tb.sv ----
// Purpose: self-checking bench for the lcd frame waveform core
// Assumes: random source ticks, main divider cut to 4
// Notes: frames timed between leading edges of the first common, or of the common phase when static
`timescale 1ns/1ps
module segment_lcd_frame_waveform_tb
  import slfw_pkg::*;
;
  localparam int MDIV = 4;
  logic CLOCK = 0;
  logic RESETN = 0;
  logic [ADDR_W-1:0] REG_ADDR = '0;
  logic [DATA_W-1:0] REG_WDATA = '0;
  logic REG_WR = 0;
  logic REG_RD = 0;
  logic MAIN_OSC_TICK = 0;
  logic CRYSTAL_TICK = 0;
  logic LFINT_TICK = 0;
  logic SLEEP_REQ = 0;
  logic [DATA_W-1:0] REG_RDATA;
  logic MODULE_RUNNING;
  logic LCD_IRQ_FLAG;
  logic [NUM_COMS-1:0] COM_ACTIVE;
  logic [NUM_COMS-1:0] COM_SELECT;
  logic COM_PHASE;
  logic [NUM_SEGS-1:0] SEG_LEVEL;
  logic [NUM_SEGS-1:0] dark [NUM_COMS];
  int last_flips;
  logic [DATA_W-1:0] pix [NUM_PIX_REGS];
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  slfw_core #(.MAIN_DIVIDE(MDIV)) slfw_core_inst (.CLOCK(CLOCK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .MAIN_OSC_TICK(MAIN_OSC_TICK), .CRYSTAL_TICK(CRYSTAL_TICK), .LFINT_TICK(LFINT_TICK),
    .SLEEP_REQ(SLEEP_REQ), .MODULE_RUNNING(MODULE_RUNNING), .LCD_IRQ_FLAG(LCD_IRQ_FLAG),
    .COM_ACTIVE(COM_ACTIVE), .COM_SELECT(COM_SELECT), .COM_PHASE(COM_PHASE), .SEG_LEVEL(SEG_LEVEL));
  slfw_glass slfw_glass_inst (.CLOCK(CLOCK), .MODULE_RUNNING(MODULE_RUNNING), .COM_SELECT(COM_SELECT),
    .COM_PHASE(COM_PHASE), .SEG_LEVEL(SEG_LEVEL), .dark(dark), .last_flips(last_flips));
  // ****
  // clock, sources, timeout
  // ****
  always #12.5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    MAIN_OSC_TICK <= 1'($urandom % 2);
    CRYSTAL_TICK <= 1'($urandom % 2);
    LFINT_TICK <= 1'($urandom % 2);
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      miscompares++;
      stop_test();
    end
  end
  // ****
  // tasks and expectations
  // ****
  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    chk(64'(got), 64'(exp));
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dv);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= dv;
    REG_WR <= 1;
    @(posedge CLOCK);
    REG_WR <= 0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] dv);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD <= 1;
    @(posedge CLOCK);
    REG_RD <= 0;
    @(negedge CLOCK);
    dv = REG_RDATA;
  endtask
  // ticks of the chosen source between two leading edges of the mark
  task automatic measure(input logic by_phase, input logic [1:0] src, output int n);
    int r;
    int k;
    logic prev;
    logic mk;
    logic ptk;
    n = 0;
    r = 0;
    k = 0;
    prev = 1;
    ptk = 0;
    // first frame skipped: main divider phase is arbitrary at enable
    while (r < 3 && k < 30000) begin
      @(negedge CLOCK);
      k++;
      mk = by_phase ? COM_PHASE : COM_SELECT[0];
      if (mk && !prev) r++;
      // tick the core sampled at the edge just gone
      if (r == 2) n += ptk;
      ptk = src == SRC_MAIN_DIV ? MAIN_OSC_TICK : src == SRC_CRYSTAL ? CRYSTAL_TICK : LFINT_TICK;
      prev = mk;
    end
  endtask
  // cycles, after a short settle, in which the drive differs from its first value
  task automatic hold(output int n);
    logic [NUM_COMS:0] snap;
    repeat (4) @(negedge CLOCK);
    snap = {COM_SELECT, COM_PHASE};
    n = 0;
    repeat (600) begin
      @(negedge CLOCK);
      if ({COM_SELECT, COM_PHASE} != snap) n++;
    end
  endtask
  task automatic shut();
    logic [DATA_W-1:0] d;
    wr(REG_PANEL_CTRL, 8'h00);
    for (int k = 0; k < 20000 && MODULE_RUNNING !== 1'b0; k++) @(negedge CLOCK);
    rd(REG_STATUS, d);
    chk(d, 8'h01);
    chk(LCD_IRQ_FLAG, 1'b1);
    wr(REG_STATUS, 8'h01);
    rd(REG_STATUS, d);
    chk(d, 8'h00);
  endtask
  function automatic int exp_frame(input logic [1:0] m, input logic [3:0] p, input logic [1:0] src);
    int mul;
    mul = (m == MUX_STATIC) ? 4 : (m == MUX_TWO) ? 2 : 1;
    exp_frame = mul * (p + 1) * SUBSTEPS * (m + 1) * ((src == SRC_MAIN_DIV) ? MDIV : 1);
  endfunction
  function automatic logic [NUM_SEGS-1:0] exp_seg(input int c);
    int b;
    b = REGS_PER_COM * c;
    exp_seg = {pix[HI_BANK_BASE+b+2][5:0], pix[HI_BANK_BASE+b+1], pix[HI_BANK_BASE+b], pix[b+2], pix[b+1], pix[b]};
  endfunction
  // ****
  // main sequence
  // ****
  initial begin
    logic [DATA_W-1:0] d;
    logic [1:0] m;
    logic [1:0] src;
    logic t;
    logic [3:0] p;
    int n;
    void'($urandom(24508));
    repeat (2) @(posedge CLOCK);
    RESETN <= 1;
    rd(REG_PANEL_CTRL, d);
    chk(d, CTL_RESET);
    rd(REG_PRESCALE, d);
    chk(d, PRESCALE_RESET);
    for (int i = 0; i < NUM_PIX_REGS; i++) begin
      pix[i] = DATA_W'($urandom);
      wr(i[ADDR_W-1:0], pix[i]);
    end
    for (int i = 0; i < NUM_PIX_REGS; i++) begin
      rd(i[ADDR_W-1:0], d);
      chk(d, pix[i]);
    end
    rd(5'h1F, d);
    chk(d, 8'h00);
    for (int i = 0; i < 8; i++) begin
      m = i[2:1];
      t = i[0];
      p = 4'($urandom % 2);
      src = 2'($urandom % 3);
      wr(REG_PRESCALE, {4'h0, p});
      wr(REG_PANEL_CTRL, {1'b1, 2'b00, t, src, m});
      measure(m == MUX_STATIC, src, n);
      chk_n(n, exp_frame(m, p, src) * ((m == MUX_STATIC && t) ? 2 : 1));
      chk(COM_ACTIVE, (2 << m) - 1);
      if (m != MUX_STATIC) chk_n(last_flips, t ? 0 : 1);
      for (int c = 0; c <= m; c++) chk(dark[c], exp_seg(c));
      if (t && m == MUX_FOUR) begin
        // third slice lies outside the update window
        for (int k = 0; k < 9000 && COM_SELECT[2] !== 1'b1; k++) @(negedge CLOCK);
        wr(5'h00, ~pix[0]);
        rd(REG_PANEL_CTRL, d);
        chk(d[CTL_LATE_WRITE_ERROR_FLAG_BIT], 1'b1);
        rd(5'h00, d);
        chk(d, pix[0]);
        wr(REG_PANEL_CTRL, {1'b1, 2'b00, t, src, m});
      end
      rd(REG_STATUS, d);
      chk(d, {6'h00, 1'b1, t && m != MUX_STATIC});
      chk({MODULE_RUNNING, LCD_IRQ_FLAG}, {1'b1, t && m != MUX_STATIC});
      shut();
    end
    wr(REG_PRESCALE, 8'h00);
    // main source, then crystal with and without sleep select; sleep only at a frame start
    for (int s = 0; s < 3; s++) begin
      wr(REG_PANEL_CTRL, {1'b1, s == 1, 2'b00, (s == 0) ? SRC_MAIN_DIV : SRC_CRYSTAL, MUX_FOUR});
      for (int k = 0; k < 3000 && COM_SELECT[3] !== 1'b1; k++) @(negedge CLOCK);
      for (int k = 0; k < 3000 && COM_SELECT[0] !== 1'b1; k++) @(negedge CLOCK);
      @(posedge CLOCK);
      SLEEP_REQ <= 1;
      hold(n);
      chk_n(n > 0, s == 2);
      @(posedge CLOCK);
      SLEEP_REQ <= 0;
    end
    shut();
    stop_test();
  end
endmodule
bind slfw_core slfw_checker slfw_checker_inst (.CLOCK(CLOCK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .MODULE_RUNNING(MODULE_RUNNING), .LCD_IRQ_FLAG(LCD_IRQ_FLAG), .COM_ACTIVE(COM_ACTIVE),
  .COM_SELECT(COM_SELECT));
